// ==== rtl/hpc_pkg.sv ====
package hpc_pkg;
    // Register word indices, byte address is index times four
    localparam logic [4:0] IDX_A = 5'h00;
    localparam logic [4:0] IDX_B = 5'h01;
    localparam logic [4:0] IDX_C = 5'h02;
    localparam logic [4:0] IDX_CTRL = 5'h03;
    localparam logic [4:0] IDX_IEA = 5'h04;
    localparam logic [4:0] IDX_IEB = 5'h05;
    localparam logic [4:0] IDX_STAT = 5'h06;
    // Index bits taken from the byte address
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 6;
    // Control field positions
    localparam int CTRL_DIR_CL = 0;
    localparam int CTRL_MODE_B = 1;
    localparam int CTRL_DIR_B = 2;
    localparam int CTRL_DIR_CU = 3;
    localparam int CTRL_DIR_A = 4;
    localparam int CTRL_MODE_A = 5;
    // Reset values: every port in simple mode, all directions input
    localparam logic [7:0] CTRL_RST = 8'h1D;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] OE_OFF = 8'hFF;
    // Third port line positions
    localparam int PC_IRQ_B = 0;
    localparam int PC_HS_B1 = 1;
    localparam int PC_HS_B2 = 2;
    localparam int PC_IRQ_A = 3;
    localparam int PC_STB_A = 4;
    localparam int PC_IBF_A = 5;
    localparam int PC_ACK_A = 6;
    localparam int PC_OBF_A = 7;

    typedef enum logic [1:0] {
        MODE_SIMPLE = 2'b00,
        MODE_STROBED = 2'b01,
        MODE_BIDIR = 2'b10
    } hpc_mode_type;

    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_DATA = 1'b1
    } hpc_phase_type;

    // Level seen on a line: own drive when enabled, else the pin
    function automatic logic [7:0] line_val(input logic [7:0] oe_n, input logic [7:0] o, input logic [7:0] i);
        return (~oe_n & o) | (oe_n & i);
    endfunction
endpackage

// ==== rtl/hpc_ahb_front.sv ====
`timescale 1ns/1ns
module hpc_ahb_front import hpc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] haddr_i,
    output logic hreadyout_o,
    output logic wr_o,
    output logic rd_o,
    output logic [4:0] idx_o
);
    hpc_phase_type ph;
    logic write_q;
    logic take;

    assign take = hsel_i && htrans_i[1] && hready_i;

    // One wait state per transfer, so a read always sees prior writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= PH_IDLE;
            hreadyout_o <= 1'b1;
            write_q <= 1'b0;
            idx_o <= 5'h00;
        end else begin
            case (ph)
                PH_IDLE: begin
                    if (take) begin
                        ph <= PH_DATA;
                        hreadyout_o <= 1'b0;
                        write_q <= hwrite_i;
                        idx_o <= haddr_i[IDX_MSB:IDX_LSB];
                    end
                end
                PH_DATA: begin
                    ph <= PH_IDLE;
                    hreadyout_o <= 1'b1;
                end
                default: begin
                    ph <= PH_IDLE;
                    hreadyout_o <= 1'b1;
                end
            endcase
        end
    end

    assign wr_o = (ph == PH_DATA) && write_q;
    assign rd_o = (ph == PH_DATA) && !write_q;

    sequence s_take;
        (ph == PH_IDLE) && take;
    endsequence
    sequence s_answer;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    AST_BUS_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
        s_take |=> s_answer) else $error("bus answer not after one wait state");
endmodule

// ==== rtl/hpc_hs_chan.sv ====
`timescale 1ns/1ns
module hpc_hs_chan import hpc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic act_i,
    input wire logic is_in_i,
    input wire logic bidir_i,
    input wire logic stb_n_i,
    input wire logic ack_n_i,
    input wire logic [7:0] port_i,
    input wire logic host_rd_i,
    input wire logic host_wr_i,
    output logic [7:0] latch_o,
    output logic ibf_o,
    output logic obf_o,
    output logic irq_o,
    output logic drv_o
);
    logic stb_q;
    logic in_ok;
    logic out_ok;
    logic stb_fall;

    assign in_ok = act_i && (is_in_i || bidir_i);
    assign out_ok = act_i && (!is_in_i || bidir_i);
    assign stb_fall = in_ok && stb_q && !stb_n_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stb_q <= 1'b1;
        end else begin
            stb_q <= stb_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_o <= 8'h00;
        end else if (stb_fall) begin
            latch_o <= port_i;
        end
    end

    // Capture wins over a host read in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || !in_ok) begin
            ibf_o <= 1'b0;
        end else if (stb_fall) begin
            ibf_o <= 1'b1;
        end else if (host_rd_i) begin
            ibf_o <= 1'b0;
        end
    end

    // Host write wins over an acknowledge in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || !out_ok) begin
            obf_o <= 1'b0;
        end else if (host_wr_i) begin
            obf_o <= 1'b1;
        end else if (!ack_n_i) begin
            obf_o <= 1'b0;
        end
    end

    assign irq_o = (in_ok && ibf_o && stb_n_i) || (out_ok && !obf_o && ack_n_i);
    // Bidirectional port drives only while acknowledge is low
    assign drv_o = act_i && (bidir_i ? !ack_n_i : !is_in_i);

    sequence s_fall;
        in_ok && stb_q && !stb_n_i;
    endsequence
    AST_STB_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fall |=> ibf_o && (latch_o == $past(port_i))) else $error("strobe did not capture data");
    AST_IBF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        ibf_o && !host_rd_i && in_ok |=> ibf_o) else $error("input full dropped without read");
    AST_OBF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        host_wr_i && out_ok |=> obf_o) else $error("output full not set by write");
    AST_ACK_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        out_ok && !ack_n_i && !host_wr_i |=> !obf_o) else $error("acknowledge did not clear output full");
endmodule

// ==== rtl/hpc_io_card.sv ====
// Functional notes
// - Twenty-four lines in three independent eight-bit ports.
// - Modes: simple, strobed handshake, bidirectional bus.
// - Simple mode: each port and each third-port nibble has its own direction.
// - Second port takes modes 0 or 1; first port 0, 1 or 2.
// - First and second port modes are chosen independently.
// - Group A enabled: high third-port bit 3 requests an interrupt.
// - Group B enabled: high third-port bit 0 requests an interrupt.
// - Two software enable registers gate which sources may interrupt.
// - Card enable plus low address lines select registers and strobes.
// - Data turns toward host on reads, toward card on writes.
// - Host transfers are eight bits; no sixteen-bit accesses.
// - Every enabled interrupt drives the one active-low request output.
// - Without handshake the third port is two four-bit ports.
// - Second-port handshake takes third-port bits 0 to 2.
// - First-port handshake takes some of third-port bits 3 to 7.
// - Strobed input: 5 full A, 4 strobe A, 3 irq A, 2 strobe B, 1 full B, 0 irq B.
// - Strobed output: 7 full A, 6 ack A, 3 irq A, 2 ack B, 1 full B, 0 irq B.
// - Bidirectional: bits 7..3 carry first-port handshake, 2..0 stay general unless the second port is strobed.
// - Third-port bits not used for handshake stay general purpose.
// - Bit 7 is the most significant bit of each port.
// - After reset all ports are simple-mode inputs, lines pulled high.
// - A low strobe captures port data into the input latch.
// - Strobe and input-full pace input; output-full and acknowledge pace output.
`timescale 1ns/1ns
module hpc_io_card import hpc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] haddr_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [7:0] first_port_lines_i,
    output logic [7:0] first_port_lines_o,
    output logic [7:0] first_port_lines_oe_n_o,
    input wire logic [7:0] second_port_lines_i,
    output logic [7:0] second_port_lines_o,
    output logic [7:0] second_port_lines_oe_n_o,
    input wire logic [7:0] third_port_lines_i,
    output logic [7:0] third_port_lines_o,
    output logic [7:0] third_port_lines_oe_n_o,
    output logic ireq_n_o
);
    ////////////////////////////////////////////////////////////////////////
    logic wr;
    logic rd;
    logic [4:0] idx;
    hpc_mode_type mode_a;
    logic mode_b;
    logic dir_a;
    logic dir_b;
    logic dir_cu;
    logic dir_cl;
    logic ien_a;
    logic ien_b;
    logic [7:0] a_reg;
    logic [7:0] b_reg;
    logic [7:0] c_reg;
    logic [7:0] a_latch;
    logic [7:0] b_latch;
    logic a_ibf;
    logic a_obf;
    logic a_irq;
    logic a_drv;
    logic b_ibf;
    logic b_obf;
    logic b_irq;
    logic b_drv;
    logic act_a;
    logic bidir_a;
    logic a_cap;
    logic [7:0] hs_own;
    logic [7:0] hs_drv;
    logic [7:0] hs_val;
    logic [7:0] gp_out;
    logic [7:0] next_c_oe_n;
    logic [7:0] next_c_out;
    logic [7:0] next_a_oe_n;
    logic [7:0] next_b_oe_n;
    logic [7:0] c_line;
    logic [7:0] rd_val;
    logic req;

    ////////////////////////////////////////////////////////////////////////
    // Bus front end and handshake channels
    hpc_ahb_front u_front (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .haddr_i(haddr_i),
        .hreadyout_o(hreadyout_o),
        .wr_o(wr),
        .rd_o(rd),
        .idx_o(idx)
    );

    assign act_a = (mode_a != MODE_SIMPLE);
    assign bidir_a = (mode_a == MODE_BIDIR);
    assign a_cap = bidir_a || dir_a;

    hpc_hs_chan u_chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(act_a),
        .is_in_i(dir_a),
        .bidir_i(bidir_a),
        .stb_n_i(third_port_lines_i[PC_STB_A]),
        .ack_n_i(third_port_lines_i[PC_ACK_A]),
        .port_i(first_port_lines_i),
        .host_rd_i(rd && (idx == IDX_A)),
        .host_wr_i(wr && (idx == IDX_A)),
        .latch_o(a_latch),
        .ibf_o(a_ibf),
        .obf_o(a_obf),
        .irq_o(a_irq),
        .drv_o(a_drv)
    );

    // Second port shares one line for strobe and acknowledge
    hpc_hs_chan u_chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(mode_b),
        .is_in_i(dir_b),
        .bidir_i(1'b0),
        .stb_n_i(third_port_lines_i[PC_HS_B2]),
        .ack_n_i(third_port_lines_i[PC_HS_B2]),
        .port_i(second_port_lines_i),
        .host_rd_i(rd && (idx == IDX_B)),
        .host_wr_i(wr && (idx == IDX_B)),
        .latch_o(b_latch),
        .ibf_o(b_ibf),
        .obf_o(b_obf),
        .irq_o(b_irq),
        .drv_o(b_drv)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode and direction control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_a <= hpc_mode_type'(CTRL_RST[CTRL_MODE_A+:2]);
            mode_b <= CTRL_RST[CTRL_MODE_B];
            dir_a <= CTRL_RST[CTRL_DIR_A];
            dir_b <= CTRL_RST[CTRL_DIR_B];
            dir_cu <= CTRL_RST[CTRL_DIR_CU];
            dir_cl <= CTRL_RST[CTRL_DIR_CL];
        end else if (wr && (idx == IDX_CTRL)) begin
            // Unused mode code is refused; modes are set independently
            if (hwdata_i[CTRL_MODE_A+:2] != 2'b11) begin
                mode_a <= hpc_mode_type'(hwdata_i[CTRL_MODE_A+:2]);
            end
            mode_b <= hwdata_i[CTRL_MODE_B];
            dir_a <= hwdata_i[CTRL_DIR_A];
            dir_b <= hwdata_i[CTRL_DIR_B];
            dir_cu <= hwdata_i[CTRL_DIR_CU];
            dir_cl <= hwdata_i[CTRL_DIR_CL];
        end
    end

    // Interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_a <= 1'b0;
            ien_b <= 1'b0;
        end else if (wr) begin
            if (idx == IDX_IEA) begin
                ien_a <= hwdata_i[0];
            end
            if (idx == IDX_IEB) begin
                ien_b <= hwdata_i[0];
            end
        end
    end

    // Output data latches, only the low byte is used
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_reg <= DATA_RST;
            b_reg <= DATA_RST;
            c_reg <= DATA_RST;
        end else if (wr) begin
            case (idx)
                IDX_A: begin
                    a_reg <= hwdata_i[7:0];
                end
                IDX_B: begin
                    b_reg <= hwdata_i[7:0];
                end
                IDX_C: begin
                    c_reg <= hwdata_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Third port line ownership
    always_comb begin
        hs_own = 8'h00;
        hs_drv = 8'h00;
        hs_val = 8'h00;
        if (mode_b) begin
            hs_own[PC_HS_B2:PC_IRQ_B] = 3'b111;
            hs_drv[PC_HS_B1:PC_IRQ_B] = 2'b11;
            hs_val[PC_IRQ_B] = b_irq;
            hs_val[PC_HS_B1] = dir_b ? b_ibf : !b_obf;
        end
        if (act_a) begin
            hs_own[PC_IRQ_A] = 1'b1;
            hs_drv[PC_IRQ_A] = 1'b1;
            hs_val[PC_IRQ_A] = a_irq;
            if (a_cap) begin
                hs_own[PC_IBF_A:PC_STB_A] = 2'b11;
                hs_drv[PC_IBF_A] = 1'b1;
                hs_val[PC_IBF_A] = a_ibf;
            end
            if (bidir_a || !dir_a) begin
                hs_own[PC_OBF_A:PC_ACK_A] = 2'b11;
                hs_drv[PC_OBF_A] = 1'b1;
                hs_val[PC_OBF_A] = !a_obf;
            end
        end
    end

    // Free bits follow the nibble directions
    assign gp_out = {{4{!dir_cu}}, {4{!dir_cl}}};
    assign next_c_oe_n = ~(hs_drv | (~hs_own & gp_out));
    assign next_c_out = (hs_own & hs_val) | (~hs_own & c_reg);
    assign next_a_oe_n = act_a ? {8{!a_drv}} : {8{dir_a}};
    assign next_b_oe_n = mode_b ? {8{!b_drv}} : {8{dir_b}};

    // Pin drivers, all released to input during reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_port_lines_oe_n_o <= OE_OFF;
            second_port_lines_oe_n_o <= OE_OFF;
            third_port_lines_oe_n_o <= OE_OFF;
            first_port_lines_o <= DATA_RST;
            second_port_lines_o <= DATA_RST;
            third_port_lines_o <= DATA_RST;
        end else begin
            first_port_lines_oe_n_o <= next_a_oe_n;
            second_port_lines_oe_n_o <= next_b_oe_n;
            third_port_lines_oe_n_o <= next_c_oe_n;
            first_port_lines_o <= a_reg;
            second_port_lines_o <= b_reg;
            third_port_lines_o <= next_c_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read path and interrupt request
    assign c_line = line_val(third_port_lines_oe_n_o, third_port_lines_o, third_port_lines_i);
    assign req = (ien_a && c_line[PC_IRQ_A]) || (ien_b && c_line[PC_IRQ_B]);

    always_comb begin
        rd_val = 8'h00;
        case (idx)
            IDX_A: begin
                if (act_a) begin
                    rd_val = a_cap ? a_latch : a_reg;
                end else begin
                    rd_val = dir_a ? first_port_lines_i : a_reg;
                end
            end
            IDX_B: begin
                if (mode_b) begin
                    rd_val = dir_b ? b_latch : b_reg;
                end else begin
                    rd_val = dir_b ? second_port_lines_i : b_reg;
                end
            end
            IDX_C: begin
                rd_val = c_line;
            end
            IDX_CTRL: begin
                rd_val = {1'b0, mode_a, dir_a, dir_cu, dir_b, mode_b, dir_cl};
            end
            IDX_IEA: begin
                rd_val = {7'h00, ien_a};
            end
            IDX_IEB: begin
                rd_val = {7'h00, ien_b};
            end
            IDX_STAT: begin
                rd_val = {1'b0, !ireq_n_o, b_irq, b_obf, b_ibf, a_irq, a_obf, a_ibf};
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (rd) begin
            hrdata_o <= {24'h000000, rd_val};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hresp_o <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ireq_n_o <= 1'b1;
        end else begin
            ireq_n_o <= !req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RESET_INPUT: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (first_port_lines_oe_n_o == OE_OFF) && (second_port_lines_oe_n_o == OE_OFF)
        && (third_port_lines_oe_n_o == OE_OFF) && (mode_a == MODE_SIMPLE) && !mode_b)
        else $error("ports not inputs after reset");
    AST_MODE_A_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_a != 2'b11) else $error("illegal first port mode");
    AST_IRQ_A: assert property (@(posedge clk_i) disable iff (rst_i)
        ien_a && c_line[PC_IRQ_A] |=> !ireq_n_o) else $error("group A request missing");
    AST_IRQ_B: assert property (@(posedge clk_i) disable iff (rst_i)
        ien_b && c_line[PC_IRQ_B] |=> !ireq_n_o) else $error("group B request missing");
    AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ien_a && c_line[PC_IRQ_A]) && !(ien_b && c_line[PC_IRQ_B]) |=> ireq_n_o)
        else $error("request without enabled source");
    AST_B_TAKEOVER: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_b |=> third_port_lines_oe_n_o[PC_HS_B2] && !third_port_lines_oe_n_o[PC_IRQ_B])
        else $error("second port handshake lines wrong");
    AST_BIDIR_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        bidir_a && !mode_b && !dir_cl |=> third_port_lines_oe_n_o[2:0] == 3'b000)
        else $error("low bits not general purpose in bidirectional mode");
    AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd ##1 !rd |-> $stable(hrdata_o)) else $error("read data changed without a read");
endmodule

// ==== verif/hpc_host_model.sv ====
`timescale 1ns/1ns
module hpc_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] haddr_o,
    output logic [31:0] hwdata_o,
    output logic tmo_o
);
    logic [31:0] last_q;

    initial begin
        hsel_o = 1'b0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        haddr_o = 32'h0;
        hwdata_o = 32'h0;
        tmo_o = 1'b0;
    end

    // Waits for hready as sampled by the next rising edge, then passes it
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge clk_i);
        while (hready_i !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk_i);
        end
        if (n >= 20) tmo_o = 1'b1;
        last_q = hrdata_i;
        @(posedge clk_i);
    endtask

    // Single whole-word transfer, only the low byte carries data
    task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        haddr_o <= {25'h0, idx, 2'h0};
        wait_rdy();
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= {24'h0, d};
        wait_rdy();
        q = last_q;
    endtask
endmodule

// ==== verif/tb_handshake_parallel_io_card.sv ====
`timescale 1ns/1ns
module tb_handshake_parallel_io_card import hpc_pkg::*;;
    logic clk_i, rst_i, hsel, hwrite, hready, hresp, tmo, ireq_n;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] pa, pb, pc, a_i, a_o, a_oe, b_i, b_o, b_oe, c_i, c_o, c_oe;
    int n_mismatch, cmp_count;

    // Pins: card drive where enabled, else the far side or the pull-up
    assign a_i = (~a_oe & a_o) | (a_oe & pa);
    assign b_i = (~b_oe & b_o) | (b_oe & pb);
    assign c_i = (~c_oe & c_o) | (c_oe & pc);

    hpc_io_card u_hpc_io_card (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .htrans_i(htrans),
        .hwrite_i(hwrite), .hready_i(hready), .haddr_i(haddr), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .first_port_lines_i(a_i), .first_port_lines_o(a_o),
        .first_port_lines_oe_n_o(a_oe), .second_port_lines_i(b_i), .second_port_lines_o(b_o),
        .second_port_lines_oe_n_o(b_oe), .third_port_lines_i(c_i), .third_port_lines_o(c_o),
        .third_port_lines_oe_n_o(c_oe), .ireq_n_o(ireq_n));

    hpc_host_model u_hpc_host_model (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .htrans_o(htrans), .hwrite_o(hwrite), .haddr_o(haddr), .hwdata_o(hwdata), .tmo_o(tmo));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [31:0] unused_q;
        u_hpc_host_model.xfer(1'b1, idx, d, unused_q);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [7:0] e);
        logic [31:0] got;
        u_hpc_host_model.xfer(1'b0, idx, 8'h00, got);
        chk(got, {24'h0, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({6'h0, hresp, a_oe, b_oe, c_oe, ireq_n}, {7'h0, 24'hFFFFFF, 1'b1});
        rd(IDX_CTRL, CTRL_RST);
    endtask

    task automatic t_simple();
        wr(IDX_CTRL, 8'h0C);
        wr(IDX_A, 8'hA5);
        wr(IDX_C, 8'h03);
        tick(1);
        chk({16'h0, a_o, a_oe}, 32'h0000A500);
        chk({24'h0, c_oe}, 32'h000000F0);
        chk({28'h0, c_o[3:0]}, 32'h00000003);
        @(posedge clk_i);
        pb <= 8'h3C;
        rd(IDX_B, 8'h3C);
        rd(IDX_A, 8'hA5);
        rd(IDX_C, 8'hF3);
        rd(5'h07, 8'h00);
    endtask

    task automatic t_strobe();
        wr(IDX_CTRL, 8'h3B);
        wr(IDX_IEA, 8'h01);
        tick(1);
        chk({24'h0, c_oe}, 32'h000000D4);
        chk({31'h0, ireq_n}, 32'h00000001);
        @(posedge clk_i);
        pa <= 8'h5A;
        pc[4] <= 1'b0;
        @(posedge clk_i);
        pc[4] <= 1'b1;
        tick(6);
        chk({29'h0, c_o[5], c_o[3], ireq_n}, 32'h00000006);
        rd(IDX_STAT, 8'h65);
        rd(IDX_A, 8'h5A);
        tick(3);
        chk({30'h0, c_o[5], ireq_n}, 32'h00000001);
        wr(IDX_B, 8'h77);
        tick(1);
        chk({15'h0, c_o[1], b_o, b_oe}, 32'h00007700);
        @(posedge clk_i);
        pc[2] <= 1'b0;
        @(posedge clk_i);
        pc[2] <= 1'b1;
        tick(3);
        chk({31'h0, c_o[1]}, 32'h00000001);
    endtask

    task automatic t_irq_b();
        wr(IDX_IEA, 8'h00);
        wr(IDX_CTRL, CTRL_RST);
        wr(IDX_IEB, 8'h01);
        tick(3);
        chk({31'h0, ireq_n}, 32'h00000000);
        @(posedge clk_i);
        pc[0] <= 1'b0;
        tick(3);
        chk({31'h0, ireq_n}, 32'h00000001);
        @(posedge clk_i);
        pc[0] <= 1'b1;
        wr(IDX_IEB, 8'h00);
        tick(3);
        chk({31'h0, ireq_n}, 32'h00000001);
    endtask

    task automatic t_bidir();
        wr(IDX_CTRL, 8'h48);
        tick(1);
        chk({24'h0, c_oe}, 32'h00000050);
        wr(IDX_A, 8'hC3);
        @(posedge clk_i);
        pc[6] <= 1'b0;
        @(posedge clk_i);
        pc[6] <= 1'b1;
        tick(1);
        chk({15'h0, c_o[7], a_o, a_oe}, 32'h0000C300);
        tick(2);
        chk({23'h0, c_o[7], a_oe}, 32'h000001FF);
        @(posedge clk_i);
        pa <= 8'h96;
        pc[4] <= 1'b0;
        @(posedge clk_i);
        pc[4] <= 1'b1;
        tick(3);
        rd(IDX_A, 8'h96);
        // Mode code 11 keeps the first port mode, the rest of the word lands
        wr(IDX_CTRL, 8'h6F);
        rd(IDX_CTRL, 8'h4F);
        @(posedge clk_i);
        pb <= 8'h5C;
        pc[2] <= 1'b0;
        @(posedge clk_i);
        pc[2] <= 1'b1;
        tick(3);
        chk({31'h0, c_o[1]}, 32'h00000001);
        rd(IDX_B, 8'h5C);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge tmo) begin
        n_mismatch++;
        summarize();
    end

    initial begin
        rst_i = 1'b1;
        pa = 8'hFF;
        pb = 8'hFF;
        pc = 8'hFF;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(1);
        t_reset();
        t_simple();
        t_strobe();
        t_irq_b();
        t_bidir();
        summarize();
    end
endmodule
